// ### sgs_pkg.sv
// shared constants and types for setting group and stage status control
package sgs_pkg;
  // setting groups
  localparam int          NUM_GROUPS         = 4;
  localparam int          GRP_W              = 2;
  localparam logic        ORDER_ASCENDING    = 1'b0;
  localparam logic        ORDER_DESCENDING   = 1'b1;
  // synchronised sampling
  localparam int          SAMPLES_PER_PERIOD = 32;
  localparam int          SAMPLE_SHIFT       = $clog2(SAMPLES_PER_PERIOD);
  // stage enable limit
  localparam int          STAGE_LIMIT_DFLT   = 30;
  localparam int          LIMIT_W            = 8;
  localparam int          WEIGHT_W           = 2;
  localparam int          DELAY_W            = 24;
  // timing
  localparam longint      CLK_HZ             = 10_000_000;
  localparam longint      PULSE_MS           = 500;
  localparam longint      IDLE_MIN           = 5;
  localparam longint      MS_PER_S           = 1000;
  localparam longint      S_PER_MIN          = 60;
  localparam logic [31:0] PULSE_CYCLES_DFLT  = 32'(CLK_HZ * PULSE_MS / MS_PER_S);
  localparam logic [31:0] IDLE_CYCLES_DFLT   = 32'(CLK_HZ * IDLE_MIN * S_PER_MIN);
  // stage status
  typedef enum logic [1:0] {
    SGS_IDLE    = 2'b00,
    SGS_BLOCKED = 2'b01,
    SGS_START   = 2'b10,
    SGS_TRIP    = 2'b11
  } sgs_stage_state_t;
endpackage

// ### sgs_stage_if.sv
// carrier between the controller and one protection stage
`timescale 1ns/1ps
interface sgs_stage_if import sgs_pkg::*; ();
  logic                   enable;
  logic                   fault;
  logic                   block;
  logic                   force_start;
  logic                   force_trip;
  logic [DELAY_W-1:0]     delay;
  sgs_stage_state_t       state;
  logic                   start;
  logic                   trip;
  modport ctl (output enable, fault, block, force_start, force_trip, delay, input state, start, trip);
  modport stg (input enable, fault, block, force_start, force_trip, delay, output state, start, trip);
endinterface

// ### sgs_stage.sv
// one protection stage: idle, blocked, start and trip sequencing
`timescale 1ns/1ps
module sgs_stage import sgs_pkg::*;
(
  // clock, reset, enable
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  // stage signals
  sgs_stage_if.stg  stg
);

  typedef struct packed {
    sgs_stage_state_t   state;
    sgs_stage_state_t   shown;
    logic [DELAY_W-1:0] cnt;
    logic               start;
    logic               trip;
  } sgs_stage_reg_t;

  sgs_stage_reg_t r;
  sgs_stage_reg_t next_r;

  // status sequencing; the delay count survives a block so the delay resumes
  always_comb
  begin
    next_r = r;
    if (!stg.enable)
    begin
      next_r.state = SGS_IDLE;
      next_r.cnt   = '0;
    end
    else
    begin
      case (r.state)
        SGS_IDLE:
        begin
          next_r.cnt = '0;
          if (stg.fault)
            next_r.state = stg.block ? SGS_BLOCKED : SGS_START;
        end
        SGS_BLOCKED:
        begin
          if (!stg.fault)
          begin
            next_r.state = SGS_IDLE;
            next_r.cnt   = '0;
          end
          else if (!stg.block)
            next_r.state = SGS_START;
        end
        SGS_START:
        begin
          if (!stg.fault)
          begin
            next_r.state = SGS_IDLE;
            next_r.cnt   = '0;
          end
          else if (stg.block)
            next_r.state = SGS_BLOCKED;
          else if (r.cnt >= stg.delay)
            next_r.state = SGS_TRIP;
          else
            next_r.cnt = r.cnt + 1'b1;
        end
        SGS_TRIP:
        begin
          // blocking is ignored once tripping
          if (!stg.fault)
          begin
            next_r.state = SGS_IDLE;
            next_r.cnt   = '0;
          end
        end
        default:
        begin
          next_r.state = SGS_IDLE;
          next_r.cnt   = '0;
        end
      endcase
    end
    // forced status overrides only what is reported, not the sequencing
    if (stg.force_trip)
      next_r.shown = SGS_TRIP;
    else if (stg.force_start)
      next_r.shown = SGS_START;
    else
      next_r.shown = next_r.state;
    next_r.start = (next_r.shown == SGS_START) || (next_r.shown == SGS_TRIP);
    next_r.trip  = (next_r.shown == SGS_TRIP);
  end

  // state register
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      r <= '0;
    else if (clk_en_i)
      r <= next_r;
  end

  assign stg.state = r.shown;
  assign stg.start = r.start;
  assign stg.trip  = r.trip;

  // checks
  sequence s_counting_done;
    clk_en_i && stg.enable && r.state == SGS_START && stg.fault && !stg.block && r.cnt >= stg.delay;
  endsequence

  property p_trip_on_expiry;
    @(posedge core_clk_i) disable iff (reset_i)
    s_counting_done |=> r.state == SGS_TRIP;
  endproperty
  a_trip_on_expiry: assert property (p_trip_on_expiry) else $error("no trip after delay expiry");

  property p_freeze_on_block;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && stg.enable && r.state == SGS_START && stg.fault && stg.block
      |=> r.state == SGS_BLOCKED && r.cnt == $past(r.cnt);
  endproperty
  a_freeze_on_block: assert property (p_freeze_on_block) else $error("delay not frozen by block");

  property p_trip_ignores_block;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && stg.enable && r.state == SGS_TRIP && stg.fault && stg.block |=> r.state == SGS_TRIP;
  endproperty
  a_trip_ignores_block: assert property (p_trip_ignores_block) else $error("block left trip");

  property p_blocked_entry;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && stg.enable && r.state == SGS_IDLE && stg.fault && stg.block |=> r.state == SGS_BLOCKED;
  endproperty
  a_blocked_entry: assert property (p_blocked_entry) else $error("blocked fault not reported");

  property p_disabled_idle;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && !stg.enable |=> r.state == SGS_IDLE;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("disabled stage not idle");

endmodule // sgs_stage

// ### sgs_group_stage_ctrl.sv
// setting group selection, stage limit, force flag and sample timing
// Function
// - constant 32 samples per measured signal period
// - each stage enabled on its own
// - refuse enables beyond weighted stage limit
// - no control input active: default group
// - active input selects its own group
// - several active: ascending or descending priority
// - one input assignment per setting group
// - virtual inputs also control setting groups
// - stage reports idle, blocked, start, trip
// - blocking signal puts detecting stage blocked
// - force flag allows half-second start/trip pulse
// - force flag clears after 5 idle minutes
// - force flag permits relay and mA forcing
// - start on fault, trip after delay
// - block freezes delay, no effect when tripping
`timescale 1ns/1ps
module sgs_group_stage_ctrl import sgs_pkg::*;
#(
  parameter int          NUM_INPUTS   = 16,
  parameter int          NUM_KEYS     = 4,
  parameter int          NUM_VIRTUAL  = 4,
  parameter int          NUM_BUTTONS  = 6,
  parameter int          NUM_STAGES   = 8,
  parameter int          PERIOD_W     = 20,
  parameter int          STAGE_LIMIT  = STAGE_LIMIT_DFLT,
  parameter logic [WEIGHT_W*NUM_STAGES-1:0] STAGE_WEIGHT = {NUM_STAGES{2'h1}},
  parameter logic [31:0] PULSE_CYCLES = PULSE_CYCLES_DFLT,
  parameter logic [31:0] IDLE_CYCLES  = IDLE_CYCLES_DFLT,
  localparam int         SRC_W        = NUM_INPUTS + NUM_KEYS + NUM_VIRTUAL,
  localparam int         SEL_W        = $clog2(SRC_W)
)
(
  // clock, reset, enable
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_i,
  input  wire logic                          clk_en_i,
  // sampling
  input  wire logic                          freq_ref_i,
  output wire logic                          sample_tick_o,
  output wire logic [PERIOD_W-1:0]           sample_interval_o,
  // group control sources and settings
  input  wire logic [NUM_INPUTS-1:0]         binary_input_line_i,
  input  wire logic [NUM_KEYS-1:0]           function_key_i,
  input  wire logic [NUM_VIRTUAL-1:0]        virtual_input_i,
  input  wire logic [NUM_GROUPS*SEL_W-1:0]   group_input_assignment_i,
  input  wire logic [NUM_GROUPS-1:0]         group_input_used_i,
  input  wire logic [GRP_W-1:0]              default_group_setting_i,
  input  wire logic                          group_conflict_order_i,
  output wire logic [GRP_W-1:0]              active_group_o,
  // stages
  input  wire logic [NUM_STAGES-1:0]         stage_enable_req_i,
  input  wire logic [NUM_STAGES-1:0]         stage_fault_i,
  input  wire logic [NUM_STAGES-1:0]         stage_block_i,
  input  wire logic [NUM_STAGES*DELAY_W-1:0] stage_delay_i,
  output wire logic [NUM_STAGES-1:0]         stage_enabled_o,
  output wire logic                          stage_limit_refused_o,
  output wire logic [NUM_STAGES*2-1:0]       stage_state_o,
  output wire logic [NUM_STAGES-1:0]         stage_start_o,
  output wire logic [NUM_STAGES-1:0]         stage_trip_o,
  // forcing
  input  wire logic [NUM_BUTTONS-1:0]        panel_button_i,
  input  wire logic                          force_flag_set_i,
  input  wire logic                          force_flag_clear_i,
  input  wire logic [NUM_STAGES-1:0]         force_start_req_i,
  input  wire logic [NUM_STAGES-1:0]         force_trip_req_i,
  input  wire logic                          relay_force_req_i,
  input  wire logic                          ma_force_req_i,
  output wire logic                          force_flag_o,
  output wire logic                          force_pulse_o,
  output wire logic                          relay_force_en_o,
  output wire logic                          ma_force_en_o
);

  typedef struct packed {
    logic [NUM_INPUTS-1:0]  bin_m;
    logic [NUM_INPUTS-1:0]  bin_s;
    logic [NUM_KEYS-1:0]    key_m;
    logic [NUM_KEYS-1:0]    key_s;
    logic [NUM_BUTTONS-1:0] btn_m;
    logic [NUM_BUTTONS-1:0] btn_s;
    logic [NUM_BUTTONS-1:0] btn_d;
    logic                   freq_m;
    logic                   freq_s;
    logic                   freq_d;
    logic [PERIOD_W-1:0]    period_cnt;
    logic [PERIOD_W-1:0]    sample_div;
    logic [PERIOD_W-1:0]    sample_cnt;
    logic                   sample_tick;
    logic [GRP_W-1:0]       group;
    logic [NUM_STAGES-1:0]  stage_en;
    logic                   refused;
    logic                   force_flag;
    logic [31:0]            idle_cnt;
    logic [31:0]            pulse_cnt;
    logic                   pulse;
    logic [NUM_STAGES-1:0]  f_start;
    logic [NUM_STAGES-1:0]  f_trip;
    logic                   relay_en;
    logic                   ma_en;
  } sgs_top_t;

  sgs_top_t r;
  sgs_top_t next_r;

  logic [SRC_W-1:0]      src;
  logic [NUM_GROUPS-1:0] grp_act;
  logic [NUM_STAGES-1:0] grant;
  logic                  key_press;
  logic                  freq_edge;

  // picks one source bit; an out-of-range selection reads inactive
  function automatic logic src_bit(input logic [SRC_W-1:0] s, input logic [SEL_W-1:0] sel);
    src_bit = (int'(sel) < SRC_W) ? s[sel] : 1'b0;
  endfunction

  // conflict resolution: ascending lets the lowest group win
  function automatic logic [GRP_W-1:0] pick_group(input logic [NUM_GROUPS-1:0] act, input logic order,
                                                  input logic [GRP_W-1:0] dflt);
    pick_group = dflt;
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      if (order == ORDER_ASCENDING && act[NUM_GROUPS-1-g])
        pick_group = GRP_W'(NUM_GROUPS - 1 - g);
      else if (order == ORDER_DESCENDING && act[g])
        pick_group = GRP_W'(g);
    end
  endfunction

  // lower-numbered stages keep their enable when the weighted budget runs out
  function automatic logic [NUM_STAGES-1:0] grant_stages(input logic [NUM_STAGES-1:0] req);
    logic [LIMIT_W-1:0] used;
    logic [LIMIT_W-1:0] w;
    used         = '0;
    w            = '0;
    grant_stages = '0;
    for (int i = 0; i < NUM_STAGES; i++)
    begin
      w = LIMIT_W'(STAGE_WEIGHT[WEIGHT_W*i +: WEIGHT_W]);
      if (req[i] && (used + w <= LIMIT_W'(STAGE_LIMIT)))
      begin
        grant_stages[i] = 1'b1;
        used            = used + w;
      end
    end
  endfunction

  // group control sources: pins after sync, virtual inputs direct
  assign src       = {virtual_input_i, r.key_s, r.bin_s};
  assign key_press = |(r.btn_s & ~r.btn_d);
  assign freq_edge = r.freq_s & ~r.freq_d;
  assign grant     = grant_stages(stage_enable_req_i);

  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_grp
    assign grp_act[g] = group_input_used_i[g] &
                        src_bit(src, group_input_assignment_i[SEL_W*g +: SEL_W]);
  end

  // next-state logic
  always_comb
  begin
    next_r        = r;
    // two-flop synchronisers for pins
    next_r.bin_m  = binary_input_line_i;
    next_r.bin_s  = r.bin_m;
    next_r.key_m  = function_key_i;
    next_r.key_s  = r.key_m;
    next_r.btn_m  = panel_button_i;
    next_r.btn_s  = r.btn_m;
    next_r.btn_d  = r.btn_s;
    next_r.freq_m = freq_ref_i;
    next_r.freq_s = r.freq_m;
    next_r.freq_d = r.freq_s;

    // period measure; interval re-derived and phase re-aligned every period
    next_r.sample_tick = 1'b0;
    if (r.period_cnt != '1)
      next_r.period_cnt = r.period_cnt + 1'b1;
    if (freq_edge)
    begin
      next_r.period_cnt  = '0;
      // spacing rounded up from the finished period length, so a period never holds a 33rd strobe
      next_r.sample_div  = PERIOD_W'(({1'b0, r.period_cnt} + (PERIOD_W+1)'(SAMPLES_PER_PERIOD))
                                     >> SAMPLE_SHIFT);
      next_r.sample_cnt  = '0;
      next_r.sample_tick = 1'b1;
    end
    else if (r.sample_cnt >= r.sample_div - 1'b1)
    begin
      next_r.sample_cnt  = '0;
      next_r.sample_tick = 1'b1;
    end
    else
      next_r.sample_cnt = r.sample_cnt + 1'b1;

    // group and stage enables, updated every cycle
    next_r.group    = pick_group(grp_act, group_conflict_order_i, default_group_setting_i);
    next_r.stage_en = grant;
    next_r.refused  = |(stage_enable_req_i & ~grant);

    // force flag with panel inactivity timeout; setting wins over clearing
    if (key_press || force_flag_set_i)
      next_r.idle_cnt = '0;
    else if (r.force_flag)
      next_r.idle_cnt = r.idle_cnt + 32'h1;
    if (force_flag_set_i)
      next_r.force_flag = 1'b1;
    else if (force_flag_clear_i || (r.force_flag && !key_press && r.idle_cnt >= IDLE_CYCLES - 32'h1))
      next_r.force_flag = 1'b0;

    // one shared pulse; requests during a running pulse are ignored
    if (r.pulse)
    begin
      if (r.pulse_cnt == '0)
      begin
        next_r.pulse   = 1'b0;
        next_r.f_start = '0;
        next_r.f_trip  = '0;
      end
      else
        next_r.pulse_cnt = r.pulse_cnt - 32'h1;
    end
    else if (r.force_flag && |(force_start_req_i | force_trip_req_i))
    begin
      next_r.pulse     = 1'b1;
      next_r.pulse_cnt = PULSE_CYCLES - 32'h1;
      next_r.f_start   = force_start_req_i;
      next_r.f_trip    = force_trip_req_i;
    end
    next_r.relay_en = r.force_flag & relay_force_req_i;
    next_r.ma_en    = r.force_flag & ma_force_req_i;
  end

  // state register
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      r <= '0;
    else if (clk_en_i)
      r <= next_r;
  end

  // protection stages
  for (genvar i = 0; i < NUM_STAGES; i++)
  begin : g_stage
    sgs_stage_if u_if ();
    assign u_if.enable      = r.stage_en[i];
    assign u_if.fault       = stage_fault_i[i];
    assign u_if.block       = stage_block_i[i];
    assign u_if.force_start = r.f_start[i];
    assign u_if.force_trip  = r.f_trip[i];
    assign u_if.delay       = stage_delay_i[DELAY_W*i +: DELAY_W];
    assign stage_state_o[2*i +: 2] = u_if.state;
    assign stage_start_o[i]        = u_if.start;
    assign stage_trip_o[i]         = u_if.trip;
    sgs_stage u_stage (
      .core_clk_i (core_clk_i),
      .reset_i    (reset_i),
      .clk_en_i   (clk_en_i),
      .stg        (u_if.stg)
    );
  end

  assign sample_tick_o         = r.sample_tick;
  assign sample_interval_o     = r.sample_div;
  assign active_group_o        = r.group;
  assign stage_enabled_o       = r.stage_en;
  assign stage_limit_refused_o = r.refused;
  assign force_flag_o          = r.force_flag;
  assign force_pulse_o         = r.pulse;
  assign relay_force_en_o      = r.relay_en;
  assign ma_force_en_o         = r.ma_en;

  // checks; helper counts enabled cycles of a force pulse
  logic [31:0] hlp_pulse_len;
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      hlp_pulse_len <= '0;
    else if (!r.pulse)
      hlp_pulse_len <= '0;
    else if (clk_en_i)
      hlp_pulse_len <= hlp_pulse_len + 32'h1;
  end

  sequence s_mid_pair;
    clk_en_i && !grp_act[0] && grp_act[1] && grp_act[2] && !grp_act[3];
  endsequence

  property p_default_group;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && grp_act == '0 |=> active_group_o == $past(default_group_setting_i);
  endproperty
  a_default_group: assert property (p_default_group) else $error("default group not taken");

  property p_single_group;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && grp_act == NUM_GROUPS'(1) << 3 |=> active_group_o == GRP_W'(3);
  endproperty
  a_single_group: assert property (p_single_group) else $error("single input group wrong");

  property p_priority;
    @(posedge core_clk_i) disable iff (reset_i)
    s_mid_pair |=> active_group_o == ($past(group_conflict_order_i) == ORDER_ASCENDING ? GRP_W'(1) : GRP_W'(2));
  endproperty
  a_priority: assert property (p_priority) else $error("group priority wrong");

  property p_limit;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i |=> (stage_enabled_o & ~$past(stage_enable_req_i)) == '0
                 && stage_limit_refused_o == (($past(stage_enable_req_i) & ~stage_enabled_o) != '0);
  endproperty
  a_limit: assert property (p_limit) else $error("stage limit grant wrong");

  property p_pulse_len;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(force_pulse_o) |-> hlp_pulse_len == PULSE_CYCLES;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("force pulse length wrong");

  property p_pulse_needs_flag;
    @(posedge core_clk_i) disable iff (reset_i)
    $rose(force_pulse_o) |-> $past(force_flag_o);
  endproperty
  a_pulse_needs_flag: assert property (p_pulse_needs_flag) else $error("pulse without force flag");

  property p_idle_timeout;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && r.force_flag && !key_press && !force_flag_set_i && r.idle_cnt >= IDLE_CYCLES - 32'h1
      |=> !force_flag_o;
  endproperty
  a_idle_timeout: assert property (p_idle_timeout) else $error("force flag not timed out");

  property p_press_restarts;
    @(posedge core_clk_i) disable iff (reset_i)
    clk_en_i && key_press |=> r.idle_cnt == '0;
  endproperty
  a_press_restarts: assert property (p_press_restarts) else $error("key press kept idle time");

  property p_relay_force;
    @(posedge core_clk_i) disable iff (reset_i)
    relay_force_en_o || ma_force_en_o |-> $past(force_flag_o);
  endproperty
  a_relay_force: assert property (p_relay_force) else $error("output forcing without flag");

endmodule // sgs_group_stage_ctrl

// ### sgs_src_model.sv
// source side model: binary input lines, function keys and virtual inputs
`timescale 1ns/1ps
module sgs_src_model
(
  // clock
  input  wire logic        core_clk_i,
  // requested source levels, binary lines first, then keys, then virtual
  input  wire logic [23:0] src_req_i,
  // driven sources
  output logic      [15:0] binary_input_line_o,
  output logic      [3:0]  function_key_o,
  output logic      [3:0]  virtual_input_o
);
  // all sources quiet at time zero; contacts move just after the edge so the sampler never races them
  initial
  begin
    {virtual_input_o, function_key_o, binary_input_line_o} = '0;
    forever
    begin
      @(posedge core_clk_i);
      #1;
      {virtual_input_o, function_key_o, binary_input_line_o} <= src_req_i;
    end
  end
endmodule // sgs_src_model

// ### tb_sgs_group_stage_ctrl.sv
// self-checking bench for setting group selection, stage status and forcing
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((e) !== (a)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb_sgs_group_stage_ctrl;
  import sgs_pkg::*;
  localparam int PC = 20;
  localparam int FP = 64;
  logic core_clk_i = 0, reset_i = 1, clk_en_i = 1, freq_ref_i = 0, group_conflict_order_i = 0;
  logic force_flag_set_i = 0, force_flag_clear_i = 0, relay_force_req_i = 1, ma_force_req_i = 1;
  logic [23:0] src_req_i = '0;
  logic [15:0] binary_input_line_i;
  logic [3:0]  function_key_i, virtual_input_i, group_input_used_i = 4'hf;
  logic [19:0] group_input_assignment_i = '1;
  logic [1:0]  default_group_setting_i = '0, active_group_o;
  logic [7:0]  stage_enable_req_i = 8'hff, stage_fault_i = '0, stage_block_i = '0;
  logic [7:0]  force_start_req_i = '0, force_trip_req_i = '0;
  logic [7:0]  stage_enabled_o, stage_start_o, stage_trip_o;
  logic [191:0] stage_delay_i = {8{24'd8}};
  logic [15:0] stage_state_o;
  logic [5:0]  panel_button_i = '0;
  logic        stage_limit_refused_o, force_flag_o, force_pulse_o, relay_force_en_o, ma_force_en_o;
  logic        sample_tick_o;
  logic [19:0] sample_interval_o;
  int          fail_count = 0, tests_run = 0, k, b, s[4], ticks = 0, t_mark = 0, tick_span = 0;
  int          q_sel[$];
  logic [7:0]  q_exp[$];
  event        ev;
  string       nm[11] = '{"group", "state", "flag", "pulse", "relay", "ma", "ticks", "interval", "enabled",
                          "refused", "startrip"};
  always #50 core_clk_i = ~core_clk_i;
  sgs_src_model u_src (.core_clk_i, .src_req_i, .binary_input_line_o(binary_input_line_i),
    .function_key_o(function_key_i), .virtual_input_o(virtual_input_i));
  sgs_group_stage_ctrl #(.PULSE_CYCLES(32'(PC)), .IDLE_CYCLES(32'd100)) u_dut (.core_clk_i,
    .reset_i, .clk_en_i, .freq_ref_i, .sample_tick_o, .sample_interval_o, .binary_input_line_i,
    .function_key_i, .virtual_input_i, .group_input_assignment_i, .group_input_used_i,
    .default_group_setting_i, .group_conflict_order_i, .active_group_o, .stage_enable_req_i,
    .stage_fault_i, .stage_block_i, .stage_delay_i, .stage_enabled_o, .stage_limit_refused_o,
    .stage_state_o, .stage_start_o, .stage_trip_o, .panel_button_i, .force_flag_set_i,
    .force_flag_clear_i, .force_start_req_i, .force_trip_req_i, .relay_force_req_i,
    .ma_force_req_i, .force_flag_o, .force_pulse_o, .relay_force_en_o, .ma_force_en_o);
  // settle after the last edge, always the same small delay
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // note an expectation for the watcher
  task automatic nt(input int sel, input logic [7:0] e);
    q_sel.push_back(sel);
    q_exp.push_back(e);
    -> ev;
  endtask
  function automatic logic [7:0] act(input int sel);
    case (sel)
      0: act = {6'h0, active_group_o};
      1: act = {6'h0, stage_state_o[2*k +: 2]};
      2: act = {7'h0, force_flag_o};
      3: act = {7'h0, force_pulse_o};
      4: act = {7'h0, relay_force_en_o};
      5: act = {7'h0, ma_force_en_o};
      6: act = 8'(tick_span);
      7: act = sample_interval_o[7:0];
      8: act = stage_enabled_o;
      9: act = {7'h0, stage_limit_refused_o};
      default: act = {6'h0, stage_trip_o[k], stage_start_o[k]};
    endcase
  endfunction
  // strobes counted on the falling edge, where the registered output has settled
  always @(negedge core_clk_i)
    if (sample_tick_o)
      ticks++;
  // watcher takes every queued note, oldest first, and compares it with what the outputs show
  always @(ev)
  begin
    while (q_sel.size() > 0)
    begin
      `CHK(nm[q_sel[0]], q_exp[0], act(q_sel[0]))
      void'(q_sel.pop_front());
      void'(q_exp.pop_front());
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog sized well beyond the few hundred cycles the tests need
  initial
  begin
    #(100 * 2000);
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(90));
    cyc(2);
    reset_i = 0;
    b = $urandom % 16;
    s = '{b, (b + 1) % 16, 17, 21};
    group_input_assignment_i = {5'd21, 5'd17, 5'((b + 1) % 16), 5'(b)};
    default_group_setting_i = 2'($urandom % 4);
    cyc(4);
    nt(0, {6'h0, default_group_setting_i});
    for (int g = 0; g < 4; g++)
    begin
      src_req_i = 24'h1 << s[g];
      cyc(5);
      nt(0, 8'(g));
    end
    src_req_i = (24'h1 << s[1]) | (24'h1 << s[2]);
    cyc(5);
    nt(0, 8'h1);
    group_conflict_order_i = 1;
    cyc(2);
    nt(0, 8'h2);
    src_req_i = '0;
    $display("test groups done");
    // strobes of one whole reference period, taken three edges after each rise (sync plus detect)
    for (int p = 0; p < 4; p++)
    begin
      freq_ref_i = 1;
      cyc(3);
      tick_span = ticks - t_mark;
      t_mark = ticks;
      cyc(FP / 2 - 3);
      freq_ref_i = 0;
      cyc(FP / 2);
    end
    nt(6, 8'(SAMPLES_PER_PERIOD));
    nt(7, 8'(FP / SAMPLES_PER_PERIOD));
    $display("test sampling done");
    k = $urandom % 8;
    stage_fault_i[k] = 1;
    cyc(2);
    nt(1, {6'h0, SGS_START});
    nt(10, 8'h1);
    stage_block_i[k] = 1;
    cyc(10);
    nt(1, {6'h0, SGS_BLOCKED});
    stage_block_i[k] = 0;
    cyc(2);
    nt(1, {6'h0, SGS_START});
    cyc(10);
    nt(1, {6'h0, SGS_TRIP});
    nt(10, 8'h3);
    stage_block_i[k] = 1;
    cyc(2);
    nt(1, {6'h0, SGS_TRIP});
    {stage_fault_i, stage_block_i} = '0;
    cyc(2);
    nt(1, {6'h0, SGS_IDLE});
    // eight stages stay well inside the limit, so every request is granted
    stage_enable_req_i = 8'($urandom);
    cyc(2);
    nt(8, stage_enable_req_i);
    nt(9, 8'h0);
    stage_enable_req_i = 8'hff;
    $display("test stage done");
    nt(4, 8'h0);
    force_flag_set_i = 1;
    cyc(1);
    force_flag_set_i = 0;
    cyc(1);
    nt(2, 8'h1);
    nt(4, 8'h1);
    nt(5, 8'h1);
    force_trip_req_i[k] = 1;
    cyc(1);
    force_trip_req_i = '0;
    cyc(2);
    nt(3, 8'h1);
    nt(1, {6'h0, SGS_TRIP});
    cyc(PC + 2);
    nt(3, 8'h0);
    nt(1, {6'h0, SGS_IDLE});
    panel_button_i = 6'h1 << ($urandom % 6);
    cyc(3);
    panel_button_i = '0;
    cyc(80);
    nt(2, 8'h1);
    cyc(40);
    nt(2, 8'h0);
    $display("test force done");
    cyc(2);
    tally_and_finish();
  end
endmodule // tb_sgs_group_stage_ctrl
